// ### dats_link.sv
// Link end: toggles out for events, synchronised toggles back in
`timescale 1ns/100ps
`default_nettype none
module dats_link
  import dats_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  dats_link_if.lnk lk,
  output logic run_tgl_o,
  output logic stop_tgl_o,
  output logic rearm_tgl_o,
  output logic met_o,
  output logic autoarm_o,
  input wire logic run_tgl_i,
  input wire logic stop_tgl_i,
  input wire logic rearm_tgl_i,
  input wire logic met_i,
  input wire logic autoarm_i
);
  dats_link_t s;
  dats_link_t n;
  logic [4:0] rx;

  // Toggles survive any phase between the two units' own clocks
  dats_sync #(.W(5)) u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({run_tgl_i, stop_tgl_i, rearm_tgl_i, met_i, autoarm_i}),
    .q_o(rx)
  );

  always_comb begin
    n = s;
    n.run_t = s.run_t ^ lk.run_p;
    n.stop_t = s.stop_t ^ lk.stop_p;
    n.rearm_t = s.rearm_t ^ lk.rearm_p;
    n.rx_prev = rx[4:2];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign lk.r_run_p = rx[4] ^ s.rx_prev[2];
  assign lk.r_stop_p = rx[3] ^ s.rx_prev[1];
  assign lk.r_rearm_p = rx[2] ^ s.rx_prev[0];
  assign lk.r_met = rx[1];
  assign lk.r_autoarm = rx[0];
  assign run_tgl_o = s.run_t;
  assign stop_tgl_o = s.stop_t;
  assign rearm_tgl_o = s.rearm_t;
  assign met_o = lk.met;
  assign autoarm_o = lk.autoarm;
endmodule
`default_nettype wire

// ### dats_link_if.sv
// Event and level signals between the controller and the link end
`timescale 1ns/100ps
`default_nettype none
interface dats_link_if;
  logic run_p;
  logic stop_p;
  logic rearm_p;
  logic met;
  logic autoarm;
  logic r_run_p;
  logic r_stop_p;
  logic r_rearm_p;
  logic r_met;
  logic r_autoarm;
  modport ctl (output run_p, stop_p, rearm_p, met, autoarm,
    input r_run_p, r_stop_p, r_rearm_p, r_met, r_autoarm);
  modport lnk (input run_p, stop_p, rearm_p, met, autoarm,
    output r_run_p, r_stop_p, r_rearm_p, r_met, r_autoarm);
endinterface
`default_nettype wire

// ### dats_partner.sv
// Behavioural model of the partner analyzer unit across the trigger link
`timescale 1ns/100ps
`default_nettype none
module dats_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_tgl_i,
  input wire logic stop_tgl_i,
  input wire logic rearm_tgl_i,
  input wire logic cmd_run_i,
  input wire logic cmd_stop_i,
  input wire logic cmd_rearm_i,
  input wire logic met_lvl_i,
  input wire logic auto_i,
  output logic run_tgl_o,
  output logic stop_tgl_o,
  output logic rearm_tgl_o,
  output logic met_o,
  output logic autoarm_o
);
  logic armed_r;
  logic [2:0] seen_r;
  wire logic [2:0] ev = {run_tgl_i, stop_tgl_i, rearm_tgl_i} ^ seen_r;
  assign autoarm_o = auto_i;
  // Met only while armed, so a stale level never opens the pair wait
  assign met_o = armed_r & met_lvl_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
      seen_r <= 3'h0;
      run_tgl_o <= 1'b0;
      stop_tgl_o <= 1'b0;
      rearm_tgl_o <= 1'b0;
    end else begin
      seen_r <= {run_tgl_i, stop_tgl_i, rearm_tgl_i};
      if (cmd_run_i) run_tgl_o <= ~run_tgl_o;
      if (cmd_stop_i) stop_tgl_o <= ~stop_tgl_o;
      if (cmd_rearm_i) rearm_tgl_o <= ~rearm_tgl_o;
      if (cmd_stop_i || (ev[1] && !auto_i)) begin
        armed_r <= 1'b0;
      end else if (cmd_run_i || cmd_rearm_i || ev[2] || ev[0]) begin
        armed_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dats_pkg.sv
// Types shared by the trigger synchronisation modules
package dats_pkg;
  typedef enum logic [2:0] {
    DATS_IDLE, DATS_ARMWAIT, DATS_COUNT, DATS_PAIRWAIT,
    DATS_TDELAY, DATS_CAPTURE, DATS_DONE
  } dats_state_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [10:0] cfg;
    logic [31:0] tword;
    logic [7:0] tcnt;
    logic [15:0] tdly;
    logic [15:0] sdly;
    logic [15:0] per;
    logic [15:0] cdly;
    logic [15:0] cwid;
    logic [31:0] expect_w;
    logic reject;
    dats_state_t st;
    logic sclk_prev;
    logic arm_prev;
    logic stop_prev;
    logic dly_on;
    logic [15:0] dly_cnt;
    logic [15:0] cnt;
    logic hit;
    logic err_seen;
    logic err_pulse;
    logic err_hold;
    logic sval;
    logic [31:0] sdat;
  } dats_core_t;
  typedef struct packed {
    logic run_t;
    logic stop_t;
    logic rearm_t;
    logic [2:0] rx_prev;
  } dats_link_t;
endpackage

// ### dats_regs.svh
// Register map, field positions, reset values and timing constants
`ifndef DATS_REGS_SVH
`define DATS_REGS_SVH
`define DATS_A_CTRL 6'h00
`define DATS_A_CFG 6'h01
`define DATS_A_TWORD 6'h02
`define DATS_A_TCNT 6'h03
`define DATS_A_TDLY 6'h04
`define DATS_A_SDLY 6'h05
`define DATS_A_PER 6'h06
`define DATS_A_CDLY 6'h07
`define DATS_A_CWID 6'h08
`define DATS_A_EXPECT 6'h09
`define DATS_A_STATUS 6'h0A
`define DATS_A_LAST 6'h0B
`define DATS_CTRL_RUN 0
`define DATS_CTRL_STOP 1
`define DATS_CTRL_SAMPLE 2
`define DATS_CFG_PAIR 0
`define DATS_CFG_RTC 1
`define DATS_CFG_AUTO 2
`define DATS_CFG_ABORT 3
`define DATS_CFG_SOE 4
`define DATS_CFG_QUAL 5
`define DATS_CFG_ARM 7
`define DATS_CFG_ESTOP 9
`define DATS_CFG_NEGCLK 10
`define DATS_STAT_REJ 0
`define DATS_STAT_ERR 1
`define DATS_STAT_RMET 2
`define DATS_STAT_BUSY 3
`define DATS_STAT_STATE 4
`define DATS_MODE_IGNORE 2'h0
`define DATS_MODE_HIGH 2'h1
`define DATS_MODE_LOW 2'h2
`define DATS_RST_CFG 11'h000
`define DATS_RST_TCNT 8'h01
`define DATS_RST_TDLY 16'h0002
`define DATS_RST_SDLY 16'h00FF
`define DATS_RST_PER 16'h0190
`define DATS_RST_DLY 16'h0000
`define DATS_CLK_NS 32'h0000_0032
`define DATS_DLY_PCT 32'h0000_005F
`define DATS_DLY_SUB_NS 32'h0000_000B
`define DATS_PCT_BASE 32'h0000_0064
`endif

// ### dats_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module dats_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [1:0][W-1:0] s_r;
  logic [1:0][W-1:0] s_nxt;

  always_comb begin
    s_nxt = {s_r[0], d_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r[1];
endmodule
`default_nettype wire

// ### dats_trig_ctl.sv
// Paired analyzer trigger and arming controller, one unit's side
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "dats_regs.svh"
module dats_trig_ctl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic samp_clk_i,
  input wire logic clk_qual_i,
  input wire logic trigger_arm_input_i,
  input wire logic ext_stop_n_i,
  input wire logic [31:0] chan_i,
  output logic link_run_tgl_o,
  output logic link_stop_tgl_o,
  output logic link_rearm_tgl_o,
  output logic link_met_o,
  output logic link_autoarm_o,
  input wire logic link_run_tgl_i,
  input wire logic link_stop_tgl_i,
  input wire logic link_rearm_tgl_i,
  input wire logic link_met_i,
  input wire logic link_autoarm_i,
  output logic sample_valid_o,
  output logic [31:0] sample_data_o,
  output logic capture_busy_o,
  output logic error_pulse_output_o,
  output logic error_hold_output_o
);
  import dats_pkg::*;

  dats_core_t s;
  dats_core_t n;
  dats_link_if lk();
  logic sync_clk, sync_qual, sync_arm, sync_stop_n;
  logic [31:0] sync_chan;
  logic [31:0] wd;
  logic [15:0] new_cdly;
  logic [16:0] target;
  logic wr, wr_bad, run_cmd, stop_cmd, samp_cmd;
  logic stop_any, run_any, rearm_ok;
  logic edge_seen, tick, qual_ok, samp, hit_now, arm_ok, estop, cmp_err;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction

  dats_sync #(.W(36)) u_pins (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({samp_clk_i, clk_qual_i, trigger_arm_input_i, ext_stop_n_i,
      chan_i}),
    .q_o({sync_clk, sync_qual, sync_arm, sync_stop_n, sync_chan})
  );

  dats_link u_link (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lk(lk.lnk),
    .run_tgl_o(link_run_tgl_o),
    .stop_tgl_o(link_stop_tgl_o),
    .rearm_tgl_o(link_rearm_tgl_o),
    .met_o(link_met_o),
    .autoarm_o(link_autoarm_o),
    .run_tgl_i(link_run_tgl_i),
    .stop_tgl_i(link_stop_tgl_i),
    .rearm_tgl_i(link_rearm_tgl_i),
    .met_i(link_met_i),
    .autoarm_i(link_autoarm_i)
  );

  // Bus write lands on the edge where the master sees ack
  assign wr = s.ack && wb_cyc_i && wb_stb_i && wb_we_i;
  always_comb begin
    wd = '0;
    if (wr) begin
      wd = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
    end
  end
  assign new_cdly = 16'(wmerge({16'h0000, s.cdly}, wb_dat_i, wb_sel_i));
  assign wr_bad = wr && wb_adr_i[7:2] == `DATS_A_CDLY &&
    32'(new_cdly) * `DATS_PCT_BASE + `DATS_DLY_SUB_NS * `DATS_PCT_BASE >
    `DATS_DLY_PCT * 32'(s.per);
  assign run_cmd = wr && wb_adr_i[7:2] == `DATS_A_CTRL &&
    wd[`DATS_CTRL_RUN];
  assign stop_cmd = wr && wb_adr_i[7:2] == `DATS_A_CTRL &&
    wd[`DATS_CTRL_STOP];
  assign samp_cmd = wr && wb_adr_i[7:2] == `DATS_A_CTRL &&
    wd[`DATS_CTRL_SAMPLE];

  // A local stop is refused while the partner holds autoarming
  assign lk.stop_p = stop_cmd && !lk.r_autoarm;
  assign lk.run_p = run_cmd;
  assign lk.autoarm = s.cfg[`DATS_CFG_AUTO];
  assign lk.met = s.st == DATS_PAIRWAIT && s.hit;
  assign stop_any = lk.stop_p || lk.r_stop_p;
  assign run_any = run_cmd || lk.r_run_p || lk.r_rearm_p;
  assign rearm_ok = s.cfg[`DATS_CFG_AUTO] &&
    !(s.cfg[`DATS_CFG_ABORT] && s.err_seen);
  assign lk.rearm_p = s.st == DATS_DONE && rearm_ok && !stop_any &&
    !run_any;

  // Sampling point is the clock edge plus this unit's own delay, so two
  // units with different delays sample skewed by the difference, each delay rounded up to whole 50 ns clocks
  assign target = {1'b0, s.cdly} +
    (s.cfg[`DATS_CFG_RTC] ? {1'b0, s.cwid} : 17'h00000);
  assign edge_seen = s.cfg[`DATS_CFG_NEGCLK] ? (s.sclk_prev && !sync_clk)
    : (!s.sclk_prev && sync_clk);
  assign tick = s.dly_on &&
    32'(s.dly_cnt) * `DATS_CLK_NS >= 32'(target);
  always_comb begin
    unique case (s.cfg[`DATS_CFG_QUAL +: 2])
      `DATS_MODE_HIGH: qual_ok = sync_qual;
      `DATS_MODE_LOW: qual_ok = !sync_qual;
      default: qual_ok = 1'b1;
    endcase
    unique case (s.cfg[`DATS_CFG_ARM +: 2])
      `DATS_MODE_HIGH: arm_ok = !s.arm_prev && sync_arm;
      `DATS_MODE_LOW: arm_ok = s.arm_prev && !sync_arm;
      default: arm_ok = 1'b1;
    endcase
  end
  assign samp = tick && qual_ok;
  assign hit_now = sync_chan == s.tword;
  assign cmp_err = s.cfg[`DATS_CFG_RTC] && sync_chan != s.expect_w;
  assign estop = s.cfg[`DATS_CFG_ESTOP] && s.stop_prev && !sync_stop_n;

  always_comb begin
    n = s;
    n.ack = wb_cyc_i && wb_stb_i && !s.ack;
    n.err_pulse = 1'b0;
    n.sval = 1'b0;
    n.sclk_prev = sync_clk;
    n.arm_prev = sync_arm;
    n.stop_prev = sync_stop_n;
    if (n.ack) begin
      unique case (wb_adr_i[7:2])
        `DATS_A_CFG: n.rdat = {21'h000000, s.cfg};
        `DATS_A_TWORD: n.rdat = s.tword;
        `DATS_A_TCNT: n.rdat = {24'h000000, s.tcnt};
        `DATS_A_TDLY: n.rdat = {16'h0000, s.tdly};
        `DATS_A_SDLY: n.rdat = {16'h0000, s.sdly};
        `DATS_A_PER: n.rdat = {16'h0000, s.per};
        `DATS_A_CDLY: n.rdat = {16'h0000, s.cdly};
        `DATS_A_CWID: n.rdat = {16'h0000, s.cwid};
        `DATS_A_EXPECT: n.rdat = s.expect_w;
        `DATS_A_STATUS: n.rdat = {25'h0000000, 3'(s.st),
          s.st != DATS_IDLE, lk.r_met, s.err_hold, s.reject};
        `DATS_A_LAST: n.rdat = s.sdat;
        default: n.rdat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (wb_adr_i[7:2])
        `DATS_A_CFG: n.cfg = 11'(wmerge({21'h000000, s.cfg}, wb_dat_i,
          wb_sel_i));
        `DATS_A_TWORD: n.tword = wmerge(s.tword, wb_dat_i, wb_sel_i);
        `DATS_A_TCNT: n.tcnt = 8'(wmerge({24'h000000, s.tcnt}, wb_dat_i,
          wb_sel_i));
        `DATS_A_TDLY: n.tdly = 16'(wmerge({16'h0000, s.tdly}, wb_dat_i,
          wb_sel_i));
        `DATS_A_SDLY: n.sdly = 16'(wmerge({16'h0000, s.sdly}, wb_dat_i,
          wb_sel_i));
        `DATS_A_PER: n.per = 16'(wmerge({16'h0000, s.per}, wb_dat_i,
          wb_sel_i));
        `DATS_A_CDLY: if (!wr_bad) n.cdly = new_cdly;
        `DATS_A_CWID: n.cwid = 16'(wmerge({16'h0000, s.cwid}, wb_dat_i,
          wb_sel_i));
        `DATS_A_EXPECT: n.expect_w = wmerge(s.expect_w, wb_dat_i,
          wb_sel_i);
        `DATS_A_STATUS: if (wd[`DATS_STAT_REJ]) n.reject = 1'b0;
        default: ;
      endcase
    end
    if (wr_bad) begin
      n.reject = 1'b1;
    end
    if (edge_seen) begin
      n.dly_on = 1'b1;
      n.dly_cnt = 16'h0000;
    end else if (tick) begin
      n.dly_on = 1'b0;
    end else if (s.dly_on) begin
      n.dly_cnt = s.dly_cnt + 16'h0001;
    end
    // Single sample touches nothing on the link
    if (samp_cmd) begin
      n.sval = 1'b1;
      n.sdat = sync_chan;
    end
    if (stop_any) begin
      n.st = DATS_IDLE;
    end else if (run_any) begin
      n.st = DATS_ARMWAIT;
      n.cnt = 16'h0000;
      n.err_seen = 1'b0;
      n.err_hold = 1'b0;
    end else begin
      unique case (s.st)
        DATS_IDLE: ;
        DATS_ARMWAIT: if (arm_ok) n.st = DATS_COUNT;
        DATS_COUNT: begin
          if (samp && hit_now) begin
            n.cnt = s.cnt + 16'h0001;
            if (n.cnt >= 16'(s.tcnt)) begin
              n.cnt = 16'h0000;
              n.hit = 1'b1;
              n.st = s.cfg[`DATS_CFG_PAIR] ? DATS_PAIRWAIT
                : DATS_TDELAY;
            end
          end
        end
        DATS_PAIRWAIT: begin
          if (samp) n.hit = hit_now;
          // Counter held until both sides show their condition met
          if (lk.met && lk.r_met) n.st = DATS_TDELAY;
        end
        DATS_TDELAY: begin
          if (samp) begin
            if (s.cnt >= s.tdly) begin
              n.cnt = 16'h0000;
              n.st = DATS_CAPTURE;
            end else begin
              n.cnt = s.cnt + 16'h0001;
            end
          end
        end
        DATS_CAPTURE: begin
          if (samp) begin
            n.sval = 1'b1;
            n.sdat = sync_chan;
            n.cnt = s.cnt + 16'h0001;
            if (n.cnt > s.sdly) n.st = DATS_DONE;
            if (cmp_err) begin
              n.err_pulse = 1'b1;
              n.err_hold = 1'b1;
              n.err_seen = 1'b1;
              if (s.cfg[`DATS_CFG_SOE]) n.st = DATS_DONE;
            end
          end
          if (estop) n.st = DATS_DONE;
        end
        DATS_DONE: begin
          n.st = DATS_IDLE;
          // Re-arm starts clean, or the old count would fire at once
          if (rearm_ok) begin
            n.st = DATS_ARMWAIT;
            n.cnt = 16'h0000;
            n.err_seen = 1'b0;
            n.err_hold = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.cfg <= `DATS_RST_CFG;
      s.tcnt <= `DATS_RST_TCNT;
      s.tdly <= `DATS_RST_TDLY;
      s.sdly <= `DATS_RST_SDLY;
      s.per <= `DATS_RST_PER;
      s.cdly <= `DATS_RST_DLY;
      s.cwid <= `DATS_RST_DLY;
      s.st <= DATS_IDLE;
    end else begin
      s <= n;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;
  assign sample_valid_o = s.sval;
  assign sample_data_o = s.sdat;
  assign capture_busy_o = s.st != DATS_IDLE;
  assign error_pulse_output_o = s.err_pulse;
  assign error_hold_output_o = s.err_hold;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pair_start;
    $past(s.st) == DATS_PAIRWAIT && s.st == DATS_TDELAY
      |-> $past(lk.met) && $past(lk.r_met);
  endproperty
  a_pair_start: assert property (p_pair_start)
    else $error("paired delay started without both conditions");

  property p_solo_start;
    $past(s.st) == DATS_COUNT &&
      (s.st == DATS_PAIRWAIT || s.st == DATS_TDELAY)
      |-> (s.st == DATS_PAIRWAIT) == $past(s.cfg[`DATS_CFG_PAIR]);
  endproperty
  a_solo_start: assert property (p_solo_start)
    else $error("trigger delay start ignored pairing setting");

  property p_run_arms;
    run_any && !stop_any |=> s.st == DATS_ARMWAIT;
  endproperty
  a_run_arms: assert property (p_run_arms)
    else $error("run did not arm the unit");

  property p_stop_rule;
    lk.stop_p |-> !lk.r_autoarm ##1 s.st == DATS_IDLE;
  endproperty
  a_stop_rule: assert property (p_stop_rule)
    else $error("stop sent or not obeyed");

  property p_rearm;
    s.st == DATS_DONE && rearm_ok && !stop_any && !run_any
      |-> lk.rearm_p ##1 (s.st == DATS_ARMWAIT &&
      link_rearm_tgl_o != $past(link_rearm_tgl_o));
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("autoarm unit failed to re-arm the pair");

  property p_abort;
    s.st == DATS_DONE && s.cfg[`DATS_CFG_ABORT] && s.err_seen
      |-> !lk.rearm_p;
  endproperty
  a_abort: assert property (p_abort)
    else $error("re-arm after compare error abort");

  property p_reject;
    wr_bad |=> s.reject && s.cdly == $past(s.cdly);
  endproperty
  a_reject: assert property (p_reject)
    else $error("oversized clock delay was accepted");

  property p_err_out;
    error_pulse_output_o |-> error_hold_output_o &&
      $past(s.st) == DATS_CAPTURE && $past(cmp_err);
  endproperty
  a_err_out: assert property (p_err_out)
    else $error("error outputs not tied to own compare error");

  c_pair: cover property (s.st == DATS_PAIRWAIT ##1 s.st == DATS_TDELAY);
  c_rearm: cover property (lk.rearm_p);
  c_reject: cover property (wr_bad);
  c_err: cover property (error_pulse_output_o);
endmodule
`default_nettype wire

// ### dats_trig_ctl_bench.sv
// Self-checking bench for one unit of the paired trigger controller
`timescale 1ns/100ps
`default_nettype none
`include "dats_regs.svh"
module dats_trig_ctl_bench;
  localparam logic [31:0] WORD = 32'hA5C3_0F96;
  logic clk_i, rst_i, cyc, stb, we, samp_clk, qual, arm_in, estop_n;
  logic pt_run, pt_stop, pt_rearm, pt_met, pt_auto;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, chan, rd;
  wire logic [31:0] wb_dat_o, sample_data_o;
  wire logic wb_ack_o, sample_valid_o, capture_busy_o, err_p, err_h;
  wire logic l_run, l_stop, l_rearm, l_met, l_auto;
  wire logic r_run, r_stop, r_rearm, r_met, r_auto;
  int fails, checks_done, cyc_n, nv, ne;
  logic [2:0] s;
  dats_trig_ctl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .samp_clk_i(samp_clk), .clk_qual_i(qual), .trigger_arm_input_i(arm_in),
    .ext_stop_n_i(estop_n), .chan_i(chan), .link_run_tgl_o(l_run),
    .link_stop_tgl_o(l_stop), .link_rearm_tgl_o(l_rearm),
    .link_met_o(l_met), .link_autoarm_o(l_auto), .link_run_tgl_i(r_run),
    .link_stop_tgl_i(r_stop), .link_rearm_tgl_i(r_rearm),
    .link_met_i(r_met), .link_autoarm_i(r_auto),
    .sample_valid_o(sample_valid_o), .sample_data_o(sample_data_o),
    .capture_busy_o(capture_busy_o), .error_pulse_output_o(err_p),
    .error_hold_output_o(err_h));
  dats_partner u_peer (.clk_i(clk_i), .rst_i(rst_i), .run_tgl_i(l_run),
    .stop_tgl_i(l_stop), .rearm_tgl_i(l_rearm), .cmd_run_i(pt_run),
    .cmd_stop_i(pt_stop), .cmd_rearm_i(pt_rearm), .met_lvl_i(pt_met),
    .auto_i(pt_auto), .run_tgl_o(r_run), .stop_tgl_o(r_stop),
    .rearm_tgl_o(r_rearm), .met_o(r_met), .autoarm_o(r_auto));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Sampling clock runs free, phase unrelated to the system clock
  initial begin
    samp_clk = 1'b0;
    #137;
    forever #200 samp_clk = ~samp_clk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      fails++;
      conclude();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic cycle; ack is awaited without assuming its latency
  task xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task ctrl(input int b);
    xfer(1'b1, `DATS_A_CTRL, 32'h1 << b);
  endtask
  task state(input logic [2:0] e);
    xfer(1'b0, `DATS_A_STATUS, 32'h0);
    chk("state", {29'h0, e}, {29'h0, rd[6:4]});
  endtask
  // Partner command, then time for its toggle to cross the link
  task pt(input logic [2:0] m);
    {pt_run, pt_stop, pt_rearm} <= m;
    @(posedge clk_i);
    {pt_run, pt_stop, pt_rearm} <= 3'h0;
    repeat (8) @(posedge clk_i);
  endtask
  task capture;
    nv = 0;
    ne = 0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_i);
      if (sample_valid_o === 1'b1) nv++;
      if (err_p === 1'b1) ne++;
      if (capture_busy_o === 1'b0) break;
    end
  endtask
  task t_reset;
    xfer(1'b0, `DATS_A_CFG, 32'h0);
    chk("cfg", {21'h0, `DATS_RST_CFG}, rd);
    xfer(1'b0, `DATS_A_TCNT, 32'h0);
    chk("tcnt", {24'h0, `DATS_RST_TCNT}, rd);
    xfer(1'b0, `DATS_A_TDLY, 32'h0);
    chk("tdly", {16'h0, `DATS_RST_TDLY}, rd);
    xfer(1'b0, `DATS_A_SDLY, 32'h0);
    chk("sdly", {16'h0, `DATS_RST_SDLY}, rd);
    xfer(1'b0, `DATS_A_PER, 32'h0);
    chk("per", {16'h0, `DATS_RST_PER}, rd);
    xfer(1'b1, 6'h0C, 32'hFFFF_FFFF);
    xfer(1'b0, 6'h0C, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task t_reject;
    xfer(1'b1, `DATS_A_CDLY, 32'd369);
    xfer(1'b0, `DATS_A_CDLY, 32'h0);
    chk("cdly max", 32'd369, rd);
    xfer(1'b1, `DATS_A_CDLY, 32'd370);
    xfer(1'b0, `DATS_A_CDLY, 32'h0);
    chk("cdly over", 32'd369, rd);
    xfer(1'b0, `DATS_A_STATUS, 32'h0);
    chk("reject", 32'h1, {31'h0, rd[0]});
    xfer(1'b1, `DATS_A_STATUS, 32'h1);
    xfer(1'b1, `DATS_A_CWID, 32'h0021);
    xfer(1'b0, `DATS_A_CWID, 32'h0);
    chk("cwid", 32'h0021, rd);
    xfer(1'b1, `DATS_A_CDLY, 32'h0);
  endtask
  task t_paired;
    s[0] = l_run;
    xfer(1'b1, `DATS_A_CFG, 32'h1);
    ctrl(`DATS_CTRL_RUN);
    chk("run toggle", {31'h0, ~s[0]}, {31'h0, l_run});
    // Observation window: long enough for many trigger samples
    repeat (150) @(posedge clk_i);
    state(3'h3);
    chk("met out", 32'h1, {31'h0, l_met});
    pt_met <= 1'b1;
    capture();
    chk("paired samples", 32'd2, 32'(nv));
    pt_met <= 1'b0;
    pt(3'b010);
  endtask
  task t_stop;
    pt(3'b100);
    chk("remote run", 32'h1, {31'h0, capture_busy_o});
    s[1] = l_stop;
    ctrl(`DATS_CTRL_STOP);
    chk("stop toggle", {31'h0, ~s[1]}, {31'h0, l_stop});
    chk("local stop", 32'h0, {31'h0, capture_busy_o});
    ctrl(`DATS_CTRL_RUN);
    pt(3'b010);
    chk("remote stop", 32'h0, {31'h0, capture_busy_o});
  endtask
  task t_auto;
    pt_auto <= 1'b1;
    ctrl(`DATS_CTRL_RUN);
    s[1] = l_stop;
    ctrl(`DATS_CTRL_STOP);
    repeat (8) @(posedge clk_i);
    chk("refused stop", {31'h0, s[1]}, {31'h0, l_stop});
    chk("still armed", 32'h1, {31'h0, capture_busy_o});
    pt(3'b010);
    chk("auto stop", 32'h0, {31'h0, capture_busy_o});
    pt(3'b001);
    chk("rearm", 32'h1, {31'h0, capture_busy_o});
    pt(3'b010);
    pt_auto <= 1'b0;
    s = {l_run, l_stop, l_rearm};
    ctrl(`DATS_CTRL_SAMPLE);
    repeat (8) @(posedge clk_i);
    chk("sample local", {29'h0, s}, {29'h0, l_run, l_stop, l_rearm});
  endtask
  task t_abort;
    xfer(1'b1, `DATS_A_EXPECT, ~WORD);
    xfer(1'b1, `DATS_A_CFG, 32'h04);
    s[2] = l_rearm;
    ctrl(`DATS_CTRL_RUN);
    for (int i = 0; i < 200 && l_rearm === s[2]; i++) begin
      @(posedge clk_i);
    end
    chk("rearm link", {31'h0, ~s[2]}, {31'h0, l_rearm});
    chk("rearmed", 32'h1, {31'h0, capture_busy_o});
    s[1] = l_stop;
    ctrl(`DATS_CTRL_STOP);
    chk("auto unit stop", {31'h0, ~s[1]}, {31'h0, l_stop});
    chk("auto unit idle", 32'h0, {31'h0, capture_busy_o});
    s[2] = l_rearm;
    xfer(1'b1, `DATS_A_CFG, 32'h0E);
    chk("auto level", 32'h1, {31'h0, l_auto});
    ctrl(`DATS_CTRL_RUN);
    capture();
    chk("err pulse", 32'h1, {31'h0, ne != 0});
    chk("err hold", 32'h1, {31'h0, err_h});
    repeat (40) @(posedge clk_i);
    chk("no rearm", 32'h0, {31'h0, capture_busy_o});
    chk("no rearm link", {31'h0, s[2]}, {31'h0, l_rearm});
  endtask
  task t_errstop;
    xfer(1'b1, `DATS_A_CFG, 32'h12);
    ctrl(`DATS_CTRL_RUN);
    capture();
    chk("soe samples", 32'd1, 32'(nv));
    chk("soe errors", 32'd1, 32'(ne));
    xfer(1'b1, `DATS_A_SDLY, 32'h20);
    xfer(1'b1, `DATS_A_CFG, 32'h200);
    ctrl(`DATS_CTRL_RUN);
    while (sample_valid_o !== 1'b1) begin
      @(posedge clk_i);
    end
    estop_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("ext stop", 32'h0, {31'h0, capture_busy_o});
    estop_n <= 1'b1;
  endtask
  initial begin
    {rst_i, cyc, stb, we, qual, arm_in} = 6'h20;
    {pt_run, pt_stop, pt_rearm, pt_met, pt_auto} = 5'h0;
    estop_n = 1'b1;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    chan = WORD;
    fails = 0;
    checks_done = 0;
    cyc_n = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_reject();
    xfer(1'b1, `DATS_A_TWORD, WORD);
    xfer(1'b1, `DATS_A_SDLY, 32'h1);
    ctrl(`DATS_CTRL_RUN);
    capture();
    chk("alone samples", 32'd2, 32'(nv));
    chk("sample data", WORD, sample_data_o);
    t_paired();
    t_stop();
    t_auto();
    t_abort();
    t_errstop();
    conclude();
  end
endmodule
`default_nettype wire
